// ---- inc/tmc_pkg.sv ----
// Shared constants for the transmitter modulation configuration registers.
// Assumes a 32-bit APB slave with word-aligned registers and a 125 MHz clock.
package tmc_pkg;
    localparam int ADDR_W = 12;

    // Register indices as printed; byte address is four times the index.
    localparam logic [7:0] IDX_AUX_MOD   = 8'h28;
    localparam logic [7:0] IDX_PT_MOD    = 8'h29;
    localparam logic [7:0] IDX_DRV_TIM   = 8'h29;
    localparam logic [7:0] IDX_OWN_CTRL  = 8'h30;
    localparam logic [7:0] IDX_OWN_STAT  = 8'h31;

    // Secondary register space sits above the primary one.
    localparam logic [ADDR_W-1:0] SPACE_B_BASE = 12'h400;

    localparam logic [ADDR_W-1:0] ADDR_PT_MOD   = {2'h0, IDX_PT_MOD, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_AUX_MOD  = SPACE_B_BASE | {2'h0, IDX_AUX_MOD, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_DRV_TIM  = SPACE_B_BASE | {2'h0, IDX_DRV_TIM, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_OWN_CTRL = SPACE_B_BASE | {2'h0, IDX_OWN_CTRL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_OWN_STAT = SPACE_B_BASE | {2'h0, IDX_OWN_STAT, 2'h0};

    localparam logic [7:0] AUX_RESET     = 8'h10;
    localparam logic [7:0] AUX_WR_MASK   = 8'hf8;
    localparam logic [7:0] PT_RESET      = 8'h70;
    localparam logic [7:0] DRV_TIM_RESET = 8'h7c;

    localparam int AUX_REG_AM_DIS = 7;
    localparam int AUX_EXT_POL    = 6;
    localparam int AUX_EXT_EN     = 5;
    localparam int AUX_DRV_LM_EN  = 4;
    localparam int AUX_RESISTIVE_AM_ENABLE_EN  = 3;
    localparam int PT_MOD_MSB     = 7;
    localparam int PT_MOD_LSB     = 4;
    localparam int PT_UNMOD_MSB   = 3;
    localparam int PT_UNMOD_LSB   = 0;
    localparam int TIM_TGT_MSB    = 7;
    localparam int TIM_TGT_LSB    = 4;
    localparam int TIM_MAN_SEL    = 3;
    localparam int TIM_CODE_MSB   = 2;
    localparam int CTRL_START     = 0;
    localparam int STAT_BUSY      = 3;
    localparam int STAT_DONE      = 4;
    localparam int STAT_REACHED   = 5;
    localparam int STAT_EFF_LSB   = 8;

    typedef enum logic [2:0] {
        TMC_TIM_SLOW   = 3'b000,
        TMC_TIM_MSLOW  = 3'b001,
        TMC_TIM_NOM    = 3'b010,
        TMC_TIM_MFAST  = 3'b011,
        TMC_TIM_FAST   = 3'b100
    } tmc_timing_t;

    typedef enum logic [1:0] {
        TMC_SRCH_IDLE    = 2'b00,
        TMC_SRCH_SETTLE  = 2'b01,
        TMC_SRCH_MEASURE = 2'b10
    } tmc_srch_state_t;

    localparam logic [3:0] RES_CODE_HIGHZ = 4'hf;
    localparam logic [3:0] RES_CODE_MIN   = 4'h0;
endpackage

// ---- inc/tmc_search_if.sv ----
// Carries the handshake between the register bank and the transient search.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface tmc_search_if;
    logic                 start;
    logic                 rf_tick;
    logic [3:0]           ratio;
    logic [3:0]           target;
    logic                 busy;
    logic                 done;
    logic                 reached;
    tmc_pkg::tmc_timing_t acq_code;

    modport ctrl (output start, rf_tick, ratio, target,
                  input  busy, done, reached, acq_code);
    modport srch (input  start, rf_tick, ratio, target,
                  output busy, done, reached, acq_code);
endinterface

// ---- hdl/tmc_res_decode.sv ----
// Maps a 4-bit passive resistance code to normalized resistance in tenths.
// Assumes the caller registers the result.
`timescale 1ns/1ps
module tmc_res_decode (
    input  wire logic [3:0]  code_in,
    output logic      [11:0] res_x10_out,
    output logic             high_z_out
);
    function automatic logic [11:0] res_of(input logic [3:0] c);
        unique case (c)
            4'h0: res_of = 12'h00a;
            4'h1: res_of = 12'h014;
            4'h2: res_of = 12'h029;
            4'h3: res_of = 12'h053;
            4'h4: res_of = 12'h07a;
            4'h5: res_of = 12'h0ab;
            4'h6: res_of = 12'h100;
            4'h7: res_of = 12'h140;
            4'h8: res_of = 12'h16e;
            4'h9: res_of = 12'h1ab;
            4'ha: res_of = 12'h200;
            4'hb: res_of = 12'h280;
            4'hc: res_of = 12'h355;
            4'hd: res_of = 12'h500;
            4'he: res_of = 12'ha00;
            4'hf: res_of = 12'hfff;
        endcase
    endfunction

    // RULE8 increasing resistance table
    assign res_x10_out = res_of(code_in);
    assign high_z_out  = (code_in == tmc_pkg::RES_CODE_HIGHZ);
endmodule

// ---- hdl/tmc_timing_search.sv ----
// Automatic driver transient search, stepping from slowest to fastest.
// Assumes rf_tick is a one-cycle pulse once per RF period.
`timescale 1ns/1ps
module tmc_timing_search (
    input  wire logic   CLK_IN,
    input  wire logic   RST_N_IN,
    tmc_search_if.srch  sif
);
    tmc_pkg::tmc_srch_state_t state;

    // One period settles each step and the next measures it, so five steps
    // fit in ten RF periods.
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state        <= tmc_pkg::TMC_SRCH_IDLE;
            sif.acq_code <= tmc_pkg::TMC_TIM_SLOW;
            sif.done     <= 1'b0;
            sif.reached  <= 1'b0;
        end else if (sif.start) begin
            // RULE10 start at slowest
            state        <= tmc_pkg::TMC_SRCH_SETTLE;
            sif.acq_code <= tmc_pkg::TMC_TIM_SLOW;
            sif.done     <= 1'b0;
            sif.reached  <= 1'b0;
        end else if (sif.rf_tick) begin
            unique case (state)
                tmc_pkg::TMC_SRCH_IDLE: begin
                    state <= tmc_pkg::TMC_SRCH_IDLE;
                end
                tmc_pkg::TMC_SRCH_SETTLE: begin
                    state <= tmc_pkg::TMC_SRCH_MEASURE;
                end
                tmc_pkg::TMC_SRCH_MEASURE: begin
                    // RULE10 stop when reached
                    if (sif.ratio >= sif.target) begin
                        state       <= tmc_pkg::TMC_SRCH_IDLE;
                        sif.done    <= 1'b1;
                        sif.reached <= 1'b1;
                    // RULE11 five steps bound
                    end else if (sif.acq_code == tmc_pkg::TMC_TIM_FAST) begin
                        state    <= tmc_pkg::TMC_SRCH_IDLE;
                        sif.done <= 1'b1;
                    end else begin
                        state        <= tmc_pkg::TMC_SRCH_SETTLE;
                        sif.acq_code <= tmc_pkg::tmc_timing_t'(sif.acq_code + 3'h1);
                    end
                end
                default: begin
                    state <= tmc_pkg::TMC_SRCH_IDLE;
                end
            endcase
        end
    end

    assign sif.busy = (state != tmc_pkg::TMC_SRCH_IDLE);
endmodule

// ---- hdl/tmc_tx_mod_regs.sv ----
// Transmitter modulation and driver timing configuration registers.
// Assumes an APB master on CLK_IN and a modulation signal synchronous to it.
`timescale 1ns/1ps

// What this block does
// RULE1: clearing bit 7 enables regulator AM using the depth index; setting disables.
// RULE2: bit 6 clear makes the load modulation pin active high, set active low.
// RULE3: load modulation pin is driven only while bit 5 is set.
// RULE4: bit 4, set after reset, enables driver load modulation with passive codes.
// RULE5: bit 3 enables resistive AM using the resistive AM level.
// RULE6: upper nibble is modulated resistance, lower nibble unmodulated.
// RULE7: software programs both codes before entering passive target mode.
// RULE8: codes 0 to 14 rise from 1.0 to 256.0; code 15 is high impedance.
// RULE9: bits 7 to 4 hold the target count of non-overlap times per RF period.
// RULE10: search starts slowest, steps faster while below target, stops at target.
// RULE11: search uses five steps and finishes within ten RF periods.
// RULE12: bit 3 picks acquired timing when clear, manual when set; resets set.
// RULE13: manual code 000 slow to 011 medium fast, 1xx fast, only when manual.
// RULE14: reserved bits of the auxiliary register read zero and do nothing.
module tmc_tx_mod_regs (
    input  wire logic        CLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [11:0] PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic        MOD_IN,
    input  wire logic        PASSIVE_TARGET_MODE_IN,
    input  wire logic [3:0]  AM_DEPTH_INDEX_IN,
    input  wire logic [6:0]  RESISTIVE_AM_LEVEL_IN,
    input  wire logic        RF_PERIOD_TICK_IN,
    input  wire logic [3:0]  RATIO_MEAS_IN,
    output logic             REG_AM_ACTIVE_OUT,
    output logic      [3:0]  AM_DEPTH_OUT,
    output logic             RESISTIVE_AM_ENABLE_ACTIVE_OUT,
    output logic      [6:0]  RESISTIVE_AM_ENABLE_LEVEL_OUT,
    output logic             DRV_LOAD_MOD_ACTIVE_OUT,
    output logic      [3:0]  DRV_RES_CODE_OUT,
    output logic      [11:0] DRV_RES_X10_OUT,
    output logic             DRV_HIGHZ_OUT,
    output logic             LOAD_MOD_OUTPUT_PIN_OUT,
    output logic             LOAD_MOD_OUTPUT_PIN_OE_OUT,
    output logic      [2:0]  DRV_TIMING_OUT
);
    logic [7:0]  auxiliary_modulation_setting;
    logic [7:0]  passive_target_modulation;
    logic [7:0]  driver_timing_control;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic        setup;
    logic        wr_en;
    logic [3:0]  next_res_code;
    logic [11:0] res_x10;
    logic        res_highz;
    logic [2:0]  manual_code;
    logic [2:0]  next_timing;
    logic        modulating;
    logic        passive_lm;

    tmc_search_if sif ();

    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    assign setup = PSEL_IN && !PENABLE_IN;
    assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN;

    // Zero-wait slave: read data is captured in the setup cycle, so the
    // access phase can answer at once from flip-flops.
    assign PREADY_OUT = 1'b1;

    // Register writes take effect at the completing edge of the access.
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            auxiliary_modulation_setting <= tmc_pkg::AUX_RESET;
        end else if (wr_en && hit(PADDR_IN, tmc_pkg::ADDR_AUX_MOD)) begin
            // RULE14 reserved bits dropped
            auxiliary_modulation_setting <= PWDATA_IN[7:0] & tmc_pkg::AUX_WR_MASK;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            passive_target_modulation <= tmc_pkg::PT_RESET;
        end else if (wr_en && hit(PADDR_IN, tmc_pkg::ADDR_PT_MOD)) begin
            passive_target_modulation <= PWDATA_IN[7:0];
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            // RULE12 resets to manual
            driver_timing_control <= tmc_pkg::DRV_TIM_RESET;
        end else if (wr_en && hit(PADDR_IN, tmc_pkg::ADDR_DRV_TIM)) begin
            driver_timing_control <= PWDATA_IN[7:0];
        end
    end

    // The start bit is a write-one pulse and is never stored.
    assign sif.start = wr_en && hit(PADDR_IN, tmc_pkg::ADDR_OWN_CTRL)
                       && PWDATA_IN[tmc_pkg::CTRL_START];
    assign sif.rf_tick = RF_PERIOD_TICK_IN;
    assign sif.ratio   = RATIO_MEAS_IN;
    // RULE9 target ratio field
    assign sif.target  = driver_timing_control[tmc_pkg::TIM_TGT_MSB:tmc_pkg::TIM_TGT_LSB];

    tmc_timing_search u_search (
        .CLK_IN   (CLK_IN),
        .RST_N_IN (RST_N_IN),
        .sif      (sif.srch)
    );

    always_comb begin
        rd_word = 32'h0;
        rd_hit  = 1'b1;
        if (hit(PADDR_IN, tmc_pkg::ADDR_AUX_MOD)) begin
            // RULE14 reserved read zero
            rd_word[7:0] = auxiliary_modulation_setting & tmc_pkg::AUX_WR_MASK;
        end else if (hit(PADDR_IN, tmc_pkg::ADDR_PT_MOD)) begin
            rd_word[7:0] = passive_target_modulation;
        end else if (hit(PADDR_IN, tmc_pkg::ADDR_DRV_TIM)) begin
            rd_word[7:0] = driver_timing_control;
        end else if (hit(PADDR_IN, tmc_pkg::ADDR_OWN_CTRL)) begin
            rd_word = 32'h0;
        end else if (hit(PADDR_IN, tmc_pkg::ADDR_OWN_STAT)) begin
            rd_word[2:0] = sif.acq_code;
            rd_word[tmc_pkg::STAT_BUSY]    = sif.busy;
            rd_word[tmc_pkg::STAT_DONE]    = sif.done;
            rd_word[tmc_pkg::STAT_REACHED] = sif.reached;
            rd_word[tmc_pkg::STAT_EFF_LSB +: 3] = DRV_TIMING_OUT;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            PRDATA_OUT  <= 32'h0;
            PSLVERR_OUT <= 1'b0;
        end else if (setup) begin
            PRDATA_OUT  <= PWRITE_IN ? 32'h0 : rd_word;
            PSLVERR_OUT <= !rd_hit;
        end
    end

    assign modulating = MOD_IN;
    // RULE4 driver load modulation
    assign passive_lm = PASSIVE_TARGET_MODE_IN
                        && auxiliary_modulation_setting[tmc_pkg::AUX_DRV_LM_EN];

    always_comb begin
        next_res_code = tmc_pkg::RES_CODE_MIN;
        if (passive_lm) begin
            // RULE6 nibble per state
            if (modulating) begin
                next_res_code = passive_target_modulation[tmc_pkg::PT_MOD_MSB:
                                                          tmc_pkg::PT_MOD_LSB];
            end else begin
                next_res_code = passive_target_modulation[tmc_pkg::PT_UNMOD_MSB:
                                                          tmc_pkg::PT_UNMOD_LSB];
            end
        end
    end

    tmc_res_decode u_res (
        .code_in     (next_res_code),
        .res_x10_out (res_x10),
        .high_z_out  (res_highz)
    );

    assign manual_code = driver_timing_control[tmc_pkg::TIM_CODE_MSB:0];

    always_comb begin
        // RULE13 manual code decode
        if (driver_timing_control[tmc_pkg::TIM_MAN_SEL]) begin
            if (manual_code[2]) begin
                next_timing = tmc_pkg::TMC_TIM_FAST;
            end else begin
                next_timing = manual_code;
            end
        // RULE12 acquired timing select
        end else begin
            next_timing = sif.acq_code;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            DRV_TIMING_OUT <= tmc_pkg::TMC_TIM_FAST;
        end else begin
            DRV_TIMING_OUT <= next_timing;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            DRV_LOAD_MOD_ACTIVE_OUT <= 1'b0;
            DRV_RES_CODE_OUT        <= tmc_pkg::RES_CODE_MIN;
            DRV_RES_X10_OUT         <= 12'h00a;
            DRV_HIGHZ_OUT           <= 1'b0;
        end else begin
            DRV_LOAD_MOD_ACTIVE_OUT <= passive_lm && modulating;
            DRV_RES_CODE_OUT        <= next_res_code;
            // RULE8 resistance and high impedance
            DRV_RES_X10_OUT         <= res_x10;
            DRV_HIGHZ_OUT           <= res_highz;
        end
    end

    // Reader-side amplitude modulation only applies outside passive target mode.
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            REG_AM_ACTIVE_OUT <= 1'b0;
            AM_DEPTH_OUT      <= 4'h0;
            RESISTIVE_AM_ENABLE_ACTIVE_OUT <= 1'b0;
            RESISTIVE_AM_ENABLE_LEVEL_OUT  <= 7'h00;
        end else begin
            // RULE1 regulator AM inverted enable
            REG_AM_ACTIVE_OUT <= !PASSIVE_TARGET_MODE_IN && modulating
                && !auxiliary_modulation_setting[tmc_pkg::AUX_REG_AM_DIS];
            AM_DEPTH_OUT      <= AM_DEPTH_INDEX_IN;
            // RULE5 resistive AM level
            RESISTIVE_AM_ENABLE_ACTIVE_OUT <= !PASSIVE_TARGET_MODE_IN && modulating
                && auxiliary_modulation_setting[tmc_pkg::AUX_RESISTIVE_AM_ENABLE_EN];
            RESISTIVE_AM_ENABLE_LEVEL_OUT  <= RESISTIVE_AM_LEVEL_IN;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            LOAD_MOD_OUTPUT_PIN_OUT    <= 1'b0;
            LOAD_MOD_OUTPUT_PIN_OE_OUT <= 1'b0;
        end else begin
            // RULE2 pin polarity
            LOAD_MOD_OUTPUT_PIN_OUT <= modulating
                ^ auxiliary_modulation_setting[tmc_pkg::AUX_EXT_POL];
            // RULE3 pin driven when enabled
            LOAD_MOD_OUTPUT_PIN_OE_OUT <= auxiliary_modulation_setting[tmc_pkg::AUX_EXT_EN];
        end
    end
endmodule

// ---- testbench/tmc_tx_mod_regs_monitor.sv ----
// Concurrent checks on the ports of the modulation register bank.
// Assumes it is bound to tmc_tx_mod_regs and sees nothing but its ports.
`timescale 1ns/1ps
module tmc_tx_mod_regs_monitor (
    input wire logic        CLK_IN,
    input wire logic        RST_N_IN,
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        MOD_IN,
    input wire logic        PASSIVE_TARGET_MODE_IN,
    input wire logic        REG_AM_ACTIVE_OUT,
    input wire logic        RESISTIVE_AM_ENABLE_ACTIVE_OUT,
    input wire logic        DRV_LOAD_MOD_ACTIVE_OUT,
    input wire logic [3:0]  DRV_RES_CODE_OUT,
    input wire logic        DRV_HIGHZ_OUT,
    input wire logic        LOAD_MOD_OUTPUT_PIN_OUT,
    input wire logic        LOAD_MOD_OUTPUT_PIN_OE_OUT,
    input wire logic [2:0]  DRV_TIMING_OUT
);
    logic [7:0] aux;
    logic [7:0] pt;
    logic [7:0] tim;
    logic       wr;
    logic       pm;
    assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
    assign pm = PASSIVE_TARGET_MODE_IN && MOD_IN;
    // Shadow copies stand in for the registers, since only the ports are visible here.
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            aux <= 8'h10;
            pt <= 8'h70;
            tim <= 8'h7c;
        end else if (wr) begin
            if (PADDR_IN == tmc_pkg::ADDR_AUX_MOD) aux <= PWDATA_IN[7:0] & 8'hf8;
            if (PADDR_IN == tmc_pkg::ADDR_PT_MOD) pt <= PWDATA_IN[7:0];
            if (PADDR_IN == tmc_pkg::ADDR_DRV_TIM) tim <= PWDATA_IN[7:0];
        end
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    a_reg_am_gate: assert property ($past(RST_N_IN) |->
        REG_AM_ACTIVE_OUT == $past(!PASSIVE_TARGET_MODE_IN && MOD_IN && !aux[7]))
        else $error("regulator AM flag wrong");
    a_ext_pin_level: assert property ($past(RST_N_IN) |->
        LOAD_MOD_OUTPUT_PIN_OUT == $past(MOD_IN ^ aux[6])) else $error("pin level wrong");
    a_ext_pin_enable: assert property ($past(RST_N_IN) |->
        LOAD_MOD_OUTPUT_PIN_OE_OUT == $past(aux[5])) else $error("pin enable wrong");
    a_drv_lm_gate: assert property ($past(RST_N_IN) |->
        DRV_LOAD_MOD_ACTIVE_OUT == $past(pm && aux[4])) else $error("driver LM flag wrong");
    a_resistive_am_enable_gate: assert property ($past(RST_N_IN) |->
        RESISTIVE_AM_ENABLE_ACTIVE_OUT == $past(!PASSIVE_TARGET_MODE_IN && MOD_IN && aux[3]))
        else $error("resistive AM flag wrong");
    a_res_nibble_pick: assert property ($past(RST_N_IN) |-> DRV_RES_CODE_OUT ==
        $past(!(PASSIVE_TARGET_MODE_IN && aux[4]) ? 4'h0 : (MOD_IN ? pt[7:4] : pt[3:0])))
        else $error("resistance code wrong");
    a_highz_code: assert property (
        DRV_HIGHZ_OUT == (DRV_RES_CODE_OUT == 4'hf)) else $error("high impedance flag wrong");
    a_manual_timing: assert property ($past(RST_N_IN) && $past(tim[3]) |->
        DRV_TIMING_OUT == $past(tim[2] ? 3'h4 : tim[2:0])) else $error("manual timing wrong");
    a_aux_resv_zero: assert property (
        PSEL_IN && PENABLE_IN && !PWRITE_IN && PADDR_IN == tmc_pkg::ADDR_AUX_MOD
        |-> PRDATA_OUT == {24'h0, aux}) else $error("aux readback wrong");
    c_aux_write: cover property (wr && PADDR_IN == tmc_pkg::ADDR_AUX_MOD);
    c_highz: cover property (DRV_HIGHZ_OUT);
    c_drv_lm: cover property (DRV_LOAD_MOD_ACTIVE_OUT && !MOD_IN);
endmodule
bind tmc_tx_mod_regs tmc_tx_mod_regs_monitor u_tmc_tx_mod_regs_monitor (
    .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
    .PRDATA_OUT(PRDATA_OUT), .MOD_IN(MOD_IN), .PASSIVE_TARGET_MODE_IN(PASSIVE_TARGET_MODE_IN),
    .REG_AM_ACTIVE_OUT(REG_AM_ACTIVE_OUT), .RESISTIVE_AM_ENABLE_ACTIVE_OUT(RESISTIVE_AM_ENABLE_ACTIVE_OUT),
    .DRV_LOAD_MOD_ACTIVE_OUT(DRV_LOAD_MOD_ACTIVE_OUT), .DRV_RES_CODE_OUT(DRV_RES_CODE_OUT),
    .DRV_HIGHZ_OUT(DRV_HIGHZ_OUT), .LOAD_MOD_OUTPUT_PIN_OUT(LOAD_MOD_OUTPUT_PIN_OUT),
    .LOAD_MOD_OUTPUT_PIN_OE_OUT(LOAD_MOD_OUTPUT_PIN_OE_OUT), .DRV_TIMING_OUT(DRV_TIMING_OUT));

// ---- testbench/tmc_tx_mod_regs_tb_top.sv ----
// Self-checking bench for the modulation register bank, driven over APB.
// Assumes the zero wait state slave and one clock output lag of the design.
`timescale 1ns/1ps
module tmc_tx_mod_regs_tb_top;
    logic        clk;
    logic        rst_n;
    logic        psel, penable, pwrite, pready, pslverr, mod, passive, tick;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  depth, ratio, am_dep, drv_code;
    logic [6:0]  level, res_lvl;
    logic        reg_am, resistive_am_enable, drv_lm, drv_hz, pin, pin_oe, er;
    logic [11:0] drv_x10;
    logic [2:0]  timing;
    int          fails, num_checks;
    logic [11:0] tbl [16] = '{12'h00a, 12'h014, 12'h029, 12'h053, 12'h07a, 12'h0ab, 12'h100,
        12'h140, 12'h16e, 12'h1ab, 12'h200, 12'h280, 12'h355, 12'h500, 12'ha00, 12'hfff};
    // The far side's measured ratio grows as the driver gets faster.
    assign ratio = {1'h0, timing} + 4'h1;
    tmc_tx_mod_regs u_tmc_tx_mod_regs (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .MOD_IN(mod),
        .PASSIVE_TARGET_MODE_IN(passive), .AM_DEPTH_INDEX_IN(depth),
        .RESISTIVE_AM_LEVEL_IN(level), .RF_PERIOD_TICK_IN(tick), .RATIO_MEAS_IN(ratio),
        .REG_AM_ACTIVE_OUT(reg_am), .AM_DEPTH_OUT(am_dep), .RESISTIVE_AM_ENABLE_ACTIVE_OUT(resistive_am_enable),
        .RESISTIVE_AM_ENABLE_LEVEL_OUT(res_lvl), .DRV_LOAD_MOD_ACTIVE_OUT(drv_lm),
        .DRV_RES_CODE_OUT(drv_code), .DRV_RES_X10_OUT(drv_x10), .DRV_HIGHZ_OUT(drv_hz),
        .LOAD_MOD_OUTPUT_PIN_OUT(pin), .LOAD_MOD_OUTPUT_PIN_OE_OUT(pin_oe),
        .DRV_TIMING_OUT(timing));
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic [31:0] d, input logic w);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
        apb(a, 32'h0, 1'h0);
        check(rd, exp);
        check({31'h0, er}, {31'h0, eerr});
    endtask
    // Outputs lag by one clock, so two edges leave them settled; the read
    // happens before this edge's updates land, so it sees the settled value.
    task automatic settle;
        repeat (2) @(posedge clk);
    endtask
    task automatic search(input logic [31:0] t, input logic [31:0] exp);
        apb(tmc_pkg::ADDR_DRV_TIM, t, 1'h1);
        apb(tmc_pkg::ADDR_OWN_CTRL, 32'h1, 1'h1);
        repeat (10) begin
            repeat (3) @(posedge clk);
            tick <= 1'h1;
            @(posedge clk);
            tick <= 1'h0;
        end
        settle;
        rdchk(tmc_pkg::ADDR_OWN_STAT, exp, 1'h0);
        check({29'h0, timing}, {29'h0, exp[10:8]});
    endtask
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        complete_run;
    end
    initial begin
        {rst_n, psel, penable, pwrite, mod, passive, tick} = 7'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        depth = 4'h9;
        level = 7'h55;
        fails = 0;
        num_checks = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rdchk(tmc_pkg::ADDR_AUX_MOD, 32'h10, 1'h0);
        rdchk(tmc_pkg::ADDR_PT_MOD, 32'h70, 1'h0);
        rdchk(tmc_pkg::ADDR_DRV_TIM, 32'h7c, 1'h0);
        rdchk(12'h0fc, 32'h0, 1'h1);
        apb(tmc_pkg::ADDR_AUX_MOD, 32'hffffffff, 1'h1);
        rdchk(tmc_pkg::ADDR_AUX_MOD, 32'hf8, 1'h0);
        mod <= 1'h1;
        apb(tmc_pkg::ADDR_AUX_MOD, 32'h08, 1'h1);
        settle;
        check({reg_am, resistive_am_enable, am_dep, res_lvl}, {2'h3, 4'h9, 7'h55});
        apb(tmc_pkg::ADDR_AUX_MOD, 32'h80, 1'h1);
        settle;
        check({reg_am, resistive_am_enable}, 2'h0);
        apb(tmc_pkg::ADDR_AUX_MOD, 32'h20, 1'h1);
        settle;
        check({pin_oe, pin}, 2'h3);
        apb(tmc_pkg::ADDR_AUX_MOD, 32'h40, 1'h1);
        settle;
        check({pin_oe, pin}, 2'h0);
        apb(tmc_pkg::ADDR_AUX_MOD, 32'h60, 1'h1);
        mod <= 1'h0;
        settle;
        check({pin_oe, pin}, 2'h3);
        apb(tmc_pkg::ADDR_AUX_MOD, 32'h10, 1'h1);
        for (int c = 0; c < 16; c++) begin
            apb(tmc_pkg::ADDR_PT_MOD, {24'h0, c[3:0], ~c[3:0]}, 1'h1);
            passive <= 1'h1;
            mod <= 1'h1;
            settle;
            check({drv_lm, drv_code, drv_x10}, {1'h1, c[3:0], tbl[c]});
            check({31'h0, drv_hz}, {31'h0, c[3:0] == 4'hf});
            mod <= 1'h0;
            settle;
            check({drv_lm, drv_code}, {1'h0, ~c[3:0]});
            passive <= 1'h0;
        end
        passive <= 1'h1;
        apb(tmc_pkg::ADDR_AUX_MOD, 32'h00, 1'h1);
        mod <= 1'h1;
        settle;
        check({drv_lm, drv_code}, 5'h0);
        passive <= 1'h0;
        for (int m = 0; m < 8; m++) begin
            apb(tmc_pkg::ADDR_DRV_TIM, 32'h78 | m, 1'h1);
            settle;
            check({29'h0, timing}, (m > 3) ? 32'h4 : m);
        end
        search(32'h30, 32'h232);
        search(32'hf0, 32'h414);
        complete_run;
    end
endmodule
